// *** aisc_defines.svh ***
`ifndef AISC_DEFINES_SVH
`define AISC_DEFINES_SVH

// Sizes
`define AISC_NCURVE 4
`define AISC_NPOINT 20
`define AISC_NSRC 42
`define AISC_TAU_W 20
`define AISC_PER_W 16

// Timing: one settings step is 5 ms, clock is 40 MHz
`define AISC_CLK_KHZ 40000
`define AISC_STEP_MS 5
`define AISC_STEP_CYCLES (`AISC_STEP_MS * `AISC_CLK_KHZ)
`define AISC_TAU_DEF_MS 1000
`define AISC_PERIOD_DEF_MS 150
`define AISC_TAU_DEF (`AISC_TAU_DEF_MS / `AISC_STEP_MS)
`define AISC_PERIOD_DEF (`AISC_PERIOD_DEF_MS / `AISC_STEP_MS)

// Value scaling: one unit is 0.00001
`define AISC_ONE 32'sh000186a0
`define AISC_HALF 32'sh0000c350
`define AISC_USED_FIXED 20'h00003

// Address fields
`define AISC_A_TOP 11
`define AISC_A_GLOBAL 10
`define AISC_A_CURVE 9:8
`define AISC_A_WORD 7:2

// Per-curve word offsets
`define AISC_W_CTRL 6'h00
`define AISC_W_TAU 6'h01
`define AISC_W_MIN 6'h02
`define AISC_W_MAX 6'h03
`define AISC_W_PERIOD 6'h04
`define AISC_W_USED 6'h05
`define AISC_W_INPUT 6'h06
`define AISC_W_OUTPUT 6'h07
`define AISC_W_PIN 6'h08
`define AISC_W_POUT 6'h20

// Global word offsets
`define AISC_W_STAT 6'h00
`define AISC_W_MASK 6'h01
`define AISC_W_OORF 6'h02

// Control word fields
`define AISC_CB_EN 0
`define AISC_CB_FILT 1
`define AISC_CB_OOR 2
`define AISC_CF_RND 5:4
`define AISC_CF_SRC 13:8

// Divider sizes
`define AISC_DIV_NW 68
`define AISC_DIV_DW 34
`define AISC_DIV_CW 7

`endif

// *** aisc_pkg.sv ***
package aisc_pkg;

  typedef enum logic [1:0] {
    AISC_RND_FLOAT,
    AISC_RND_FLOOR,
    AISC_RND_CEIL,
    AISC_RND_NEAR
  } aisc_round_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_SAMPLE,
    S_FILT,
    S_FWAIT,
    S_CHECK,
    S_SCAN,
    S_IDIV,
    S_IWAIT,
    S_ROUND
  } aisc_state_t;

endpackage

// *** aisc_divider.sv ***
`timescale 1ns/100ps
`include "aisc_defines.svh"

module aisc_divider (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic signed [`AISC_DIV_NW-1:0] num,
  input wire logic [`AISC_DIV_DW-1:0] den,
  output logic busy,
  output logic signed [`AISC_DIV_NW-1:0] quo
);

  logic [`AISC_DIV_NW-1:0] mag_r;
  logic [`AISC_DIV_DW-1:0] rem_r;
  logic [`AISC_DIV_DW-1:0] den_r;
  logic [`AISC_DIV_CW-1:0] cnt_r;
  logic neg_r;
  logic [`AISC_DIV_DW:0] shl;

  assign shl = {rem_r, mag_r[`AISC_DIV_NW-1]};

  // Restoring division on magnitudes, one quotient bit per clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mag_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      neg_r <= 1'b0;
    end else if (start) begin
      mag_r <= num[`AISC_DIV_NW-1] ? `AISC_DIV_NW'(-num) : num;
      rem_r <= '0;
      den_r <= den;
      neg_r <= num[`AISC_DIV_NW-1];
      cnt_r <= `AISC_DIV_CW'(`AISC_DIV_NW);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
      if (shl >= {1'b0, den_r}) begin
        rem_r <= `AISC_DIV_DW'(shl - {1'b0, den_r});
        mag_r <= {mag_r[`AISC_DIV_NW-2:0], 1'b1};
      end else begin
        rem_r <= `AISC_DIV_DW'(shl);
        mag_r <= {mag_r[`AISC_DIV_NW-2:0], 1'b0};
      end
    end
  end

  // Truncates toward zero, so a negative slope never overshoots its point
  assign busy = (cnt_r != '0);
  assign quo = neg_r ? -$signed(mag_r) : $signed(mag_r);

endmodule

// *** aisc_top.sv ***
// Functional notes
// - With filtering on, input is averaged by a first-order low-pass of set time.
// - Time constant is only reachable while filtering for that curve is on.
// - Out-of-range check works only when its enable is set; default off.
// - Flag raised when input is below the settable minimum limit.
// - Flag raised when input is above the settable maximum limit.
// - Each of the four curves drives its own out-of-range output bit.
// - On signal loss the last valid measured value is held.
// - Input refreshed once per update cycle, set in 5 ms steps, default 150 ms.
// - Output form: float, round down, round up or round to nearest.
// - Default curve has two points, inputs 0 and 1, outputs settable.
// - Up to twenty points, each enabled on its own, extra ones unused by default; points 0 and 1 are always in use.
// - Received input and computed output of each curve are readable.
// - Per-curve enable, default off, turns on curve and its measurement.
// - Each curve picks one input source; default is source zero.
// - Per-curve filtering enable, default off.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "aisc_defines.svh"

module aisc_top
  import aisc_pkg::*;
#(
  parameter int STEP_CYCLES = `AISC_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_sel,
  input wire logic [11:0] wb_adr,
  input wire logic [31:0] wb_wdat,
  output logic [31:0] wb_rdat,
  output logic wb_ack,
  input wire logic signed [31:0] src_data [`AISC_NSRC],
  input wire logic [`AISC_NSRC-1:0] src_valid,
  output logic [`AISC_NCURVE-1:0] oor,
  output logic irq
);

  localparam int NC = `AISC_NCURVE;
  localparam int NP = `AISC_NPOINT;
  localparam int PW = $clog2(STEP_CYCLES + 1);

  // Settings
  logic [NC-1:0] en_r;
  logic [NC-1:0] filt_en_r;
  logic [NC-1:0] oor_en_r;
  aisc_round_t rnd_r [NC];
  logic [5:0] src_r [NC];
  logic [`AISC_TAU_W-1:0] tau_r [NC];
  logic [`AISC_PER_W-1:0] per_r [NC];
  logic signed [31:0] min_r [NC];
  logic signed [31:0] max_r [NC];
  logic [NP-1:0] used_r [NC];
  logic signed [31:0] pin_r [NC][NP];
  logic signed [31:0] pout_r [NC][NP];

  // Datapath state
  logic signed [31:0] meas_r [NC];
  logic signed [31:0] filt_r [NC];
  logic signed [31:0] out_r [NC];
  logic [NC-1:0] oor_r;
  logic [NC-1:0] oor_q_r;
  logic [NC-1:0] pend_r;
  logic [NC-1:0] pick;
  logic [1:0] pick_idx;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  aisc_state_t state_r;
  logic [1:0] cur_r;
  logic [4:0] idx_r;
  logic [4:0] lo_r;
  logic [4:0] hi_r;
  logic lo_ok_r;
  logic hi_ok_r;
  logic signed [31:0] res_r;
  logic done_r;
  logic [PW-1:0] pre_r;
  logic step;

  // Bus decode
  logic glob;
  logic mapped;
  logic [1:0] bc;
  logic [5:0] bw;
  logic wr_ev;
  logic [31:0] rd;
  logic [31:0] wm;
  logic [5:0] pi;
  logic [5:0] po;

  // Divider hookup
  logic div_start;
  logic signed [`AISC_DIV_NW-1:0] div_num;
  logic [`AISC_DIV_DW-1:0] div_den;
  logic div_busy;
  logic signed [`AISC_DIV_NW-1:0] div_quo;

  // Current-curve views
  logic [5:0] sel;
  logic [63:0] vpad;
  logic src_ok;
  logic signed [31:0] xin;

  // Point window decode, shared by the read and write paths
  function automatic logic [5:0] pt_dec(input logic [5:0] w, input logic [5:0] base);
    logic [5:0] d;
    d = w - base;
    pt_dec = {(w >= base) && (d < 6'(`AISC_NPOINT)), d[4:0]};
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    bmerge = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        bmerge[k*8 +: 8] = n[k*8 +: 8];
      end
    end
  endfunction

  // Rounding to whole numbers, multiples of AISC_ONE; nearest rounds halves away from zero
  function automatic logic signed [31:0] round_val(input logic signed [31:0] v,
                                                   input aisc_round_t m);
    logic signed [31:0] r;
    r = v % `AISC_ONE;
    unique case (m)
      AISC_RND_FLOAT: round_val = v;
      AISC_RND_FLOOR: round_val = (r < 0) ? v - r - `AISC_ONE : v - r;
      AISC_RND_CEIL: round_val = (r > 0) ? v - r + `AISC_ONE : v - r;
      AISC_RND_NEAR: round_val = (r >= `AISC_HALF) ? v - r + `AISC_ONE :
                                 (r <= -`AISC_HALF) ? v - r - `AISC_ONE : v - r;
    endcase
  endfunction

  assign glob = wb_adr[`AISC_A_GLOBAL];
  assign mapped = !wb_adr[`AISC_A_TOP];
  assign bc = wb_adr[`AISC_A_CURVE];
  assign bw = wb_adr[`AISC_A_WORD];
  assign wr_ev = wb_cyc && wb_stb && wb_ack && wb_we && mapped;
  assign wm = bmerge(rd, wb_wdat, wb_sel);
  assign pi = pt_dec(bw, `AISC_W_PIN);
  assign po = pt_dec(bw, `AISC_W_POUT);

  // Read mux; unmapped words read as zero
  always_comb begin
    rd = '0;
    if (mapped && glob) begin
      unique case (bw)
        `AISC_W_STAT: rd = 32'(stat_r);
        `AISC_W_MASK: rd = 32'(mask_r);
        `AISC_W_OORF: rd = 32'(oor_r);
        default: rd = '0;
      endcase
    end else if (mapped) begin
      unique case (bw)
        `AISC_W_CTRL: begin
          rd[`AISC_CB_EN] = en_r[bc];
          rd[`AISC_CB_FILT] = filt_en_r[bc];
          rd[`AISC_CB_OOR] = oor_en_r[bc];
          rd[`AISC_CF_RND] = rnd_r[bc];
          rd[`AISC_CF_SRC] = src_r[bc];
        end
        `AISC_W_TAU: rd = filt_en_r[bc] ? 32'(tau_r[bc]) : '0;
        `AISC_W_MIN: rd = min_r[bc];
        `AISC_W_MAX: rd = max_r[bc];
        `AISC_W_PERIOD: rd = 32'(per_r[bc]);
        `AISC_W_USED: rd = 32'(used_r[bc]);
        `AISC_W_INPUT: rd = meas_r[bc];
        `AISC_W_OUTPUT: rd = out_r[bc];
        default: begin
          if (pi[5]) begin
            rd = pin_r[bc][pi[4:0]];
          end else if (po[5]) begin
            rd = pout_r[bc][po[4:0]];
          end
        end
      endcase
    end
  end

  // Classic slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack <= 1'b0;
      wb_rdat <= '0;
    end else begin
      wb_ack <= wb_cyc && wb_stb && !wb_ack;
      if (wb_cyc && wb_stb && !wb_ack) begin
        wb_rdat <= rd;
      end
    end
  end

  // Settings; points 0 and 1 stay in use whatever software writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= '0;
      filt_en_r <= '0;
      oor_en_r <= '0;
      for (int c = 0; c < NC; c++) begin
        rnd_r[c] <= AISC_RND_FLOAT;
        src_r[c] <= '0;
        tau_r[c] <= `AISC_TAU_W'(`AISC_TAU_DEF);
        per_r[c] <= `AISC_PER_W'(`AISC_PERIOD_DEF);
        min_r[c] <= '0;
        max_r[c] <= '0;
        used_r[c] <= `AISC_USED_FIXED;
        for (int p = 0; p < NP; p++) begin
          pin_r[c][p] <= '0;
          pout_r[c][p] <= '0;
        end
        pin_r[c][1] <= `AISC_ONE;
      end
    end else if (wr_ev && !glob) begin
      unique case (bw)
        `AISC_W_CTRL: begin
          en_r[bc] <= wm[`AISC_CB_EN];
          filt_en_r[bc] <= wm[`AISC_CB_FILT];
          oor_en_r[bc] <= wm[`AISC_CB_OOR];
          rnd_r[bc] <= aisc_round_t'(wm[`AISC_CF_RND]);
          src_r[bc] <= wm[`AISC_CF_SRC];
        end
        `AISC_W_TAU: begin
          // Zero would mean no averaging at all; hold it at one step
          if (filt_en_r[bc]) begin
            tau_r[bc] <= (wm[`AISC_TAU_W-1:0] == '0) ? `AISC_TAU_W'(1) : wm[`AISC_TAU_W-1:0];
          end
        end
        `AISC_W_MIN: min_r[bc] <= wm;
        `AISC_W_MAX: max_r[bc] <= wm;
        `AISC_W_PERIOD: begin
          per_r[bc] <= (wm[`AISC_PER_W-1:0] == '0) ? `AISC_PER_W'(1) : wm[`AISC_PER_W-1:0];
        end
        `AISC_W_USED: used_r[bc] <= wm[NP-1:0] | `AISC_USED_FIXED;
        default: begin
          if (pi[5]) begin
            pin_r[bc][pi[4:0]] <= wm;
          end else if (po[5]) begin
            pout_r[bc][po[4:0]] <= wm;
          end
        end
      endcase
    end
  end

  // 5 ms step prescaler shared by all curves
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= step ? '0 : pre_r + 1'b1;
    end
  end
  assign step = (pre_r == PW'(STEP_CYCLES - 1));

  // Per-curve update cycle counters; a pending request survives its own clear
  for (genvar c = 0; c < NC; c++) begin : g_curve
    logic [`AISC_PER_W-1:0] cnt_r;
    logic pend_c_r;
    logic wrap;
    assign wrap = step && (cnt_r + 1'b1 >= per_r[c]);
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cnt_r <= '0;
        pend_c_r <= 1'b0;
      end else begin
        if (!en_r[c]) begin
          cnt_r <= '0;
        end else if (step) begin
          cnt_r <= wrap ? '0 : cnt_r + 1'b1;
        end
        pend_c_r <= en_r[c] && ((pend_c_r && !pick[c]) || wrap);
      end
    end
    assign pend_r[c] = pend_c_r;
  end

  // Lowest pending curve is served first
  always_comb begin
    pick = '0;
    pick_idx = '0;
    for (int c = NC - 1; c >= 0; c--) begin
      if (pend_r[c]) begin
        pick_idx = 2'(c);
      end
    end
    if (state_r == S_IDLE && |pend_r) begin
      pick[pick_idx] = 1'b1;
    end
  end

  assign sel = src_r[cur_r];
  assign vpad = 64'(src_valid);
  assign src_ok = (sel < 6'(`AISC_NSRC)) && vpad[sel];
  assign xin = filt_r[cur_r];

  // Divider operands: filter step or interpolation
  always_comb begin
    div_start = 1'b0;
    div_num = '0;
    div_den = '0;
    if (state_r == S_FILT && filt_en_r[cur_r]) begin
      div_start = 1'b1;
      // y += (x - y) * T / (T + tau), a discrete 1/(1 + s/wc)
      div_num = `AISC_DIV_NW'(33'(meas_r[cur_r]) - 33'(xin)) *
                `AISC_DIV_NW'($signed({1'b0, per_r[cur_r]}));
      div_den = `AISC_DIV_DW'(per_r[cur_r]) + `AISC_DIV_DW'(tau_r[cur_r]);
    end else if (state_r == S_IDIV && lo_ok_r && hi_ok_r) begin
      div_start = 1'b1;
      div_num = `AISC_DIV_NW'(33'(xin) - 33'(pin_r[cur_r][lo_r])) *
                `AISC_DIV_NW'(33'(pout_r[cur_r][hi_r]) - 33'(pout_r[cur_r][lo_r]));
      div_den = `AISC_DIV_DW'(pin_r[cur_r][hi_r]) - `AISC_DIV_DW'(pin_r[cur_r][lo_r]);
    end
  end

  aisc_divider u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .quo(div_quo)
  );

  // Update sequencer, one curve at a time
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      idx_r <= '0;
      lo_r <= '0;
      hi_r <= '0;
      lo_ok_r <= 1'b0;
      hi_ok_r <= 1'b0;
      res_r <= '0;
      done_r <= 1'b0;
      oor_r <= '0;
      for (int c = 0; c < NC; c++) begin
        meas_r[c] <= '0;
        filt_r[c] <= '0;
        out_r[c] <= '0;
      end
    end else begin
      done_r <= 1'b0;
      for (int c = 0; c < NC; c++) begin
        if (!en_r[c] || !oor_en_r[c]) begin
          oor_r[c] <= 1'b0;
        end
      end
      unique case (state_r)
        S_IDLE: begin
          if (|pend_r) begin
            cur_r <= pick_idx;
            state_r <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          // A lost source leaves the last good value in place
          if (src_ok) begin
            meas_r[cur_r] <= src_data[sel];
          end
          state_r <= S_FILT;
        end
        S_FILT: begin
          if (filt_en_r[cur_r]) begin
            state_r <= S_FWAIT;
          end else begin
            filt_r[cur_r] <= meas_r[cur_r];
            state_r <= S_CHECK;
          end
        end
        S_FWAIT: begin
          if (!div_busy) begin
            filt_r[cur_r] <= xin + div_quo[31:0];
            state_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (en_r[cur_r] && oor_en_r[cur_r]) begin
            oor_r[cur_r] <= (xin < min_r[cur_r]) || (xin > max_r[cur_r]);
          end
          idx_r <= '0;
          lo_ok_r <= 1'b0;
          hi_ok_r <= 1'b0;
          state_r <= S_SCAN;
        end
        S_SCAN: begin
          // Points are expected in rising input order
          if (used_r[cur_r][idx_r]) begin
            if (pin_r[cur_r][idx_r] <= xin) begin
              lo_r <= idx_r;
              lo_ok_r <= 1'b1;
            end else if (!hi_ok_r) begin
              hi_r <= idx_r;
              hi_ok_r <= 1'b1;
            end
          end
          idx_r <= idx_r + 1'b1;
          if (idx_r == 5'(NP - 1)) begin
            state_r <= S_IDIV;
          end
        end
        S_IDIV: begin
          if (lo_ok_r && hi_ok_r) begin
            state_r <= S_IWAIT;
          end else begin
            // Outside the curve the end point's output is held
            res_r <= lo_ok_r ? pout_r[cur_r][lo_r] : pout_r[cur_r][hi_r];
            state_r <= S_ROUND;
          end
        end
        S_IWAIT: begin
          if (!div_busy) begin
            res_r <= pout_r[cur_r][lo_r] + div_quo[31:0];
            state_r <= S_ROUND;
          end
        end
        S_ROUND: begin
          out_r[cur_r] <= round_val(res_r, rnd_r[cur_r]);
          done_r <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Sticky events: low nibble out-of-range rise, high nibble update done
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= '0;
      mask_r <= '0;
      oor_q_r <= '0;
    end else begin
      oor_q_r <= oor_r;
      stat_r <= (stat_r & ~((wr_ev && glob && bw == `AISC_W_STAT) ? wm[7:0] : 8'h00)) |
                {(NC'(done_r) << cur_r), oor_r & ~oor_q_r};
      if (wr_ev && glob && bw == `AISC_W_MASK) begin
        mask_r <= wm[7:0];
      end
    end
  end

  assign oor = oor_r;
  assign irq = |(stat_r & mask_r);

  AST_TAU_LOCK: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_ev && !glob && bw == `AISC_W_TAU && !filt_en_r[bc])
    |=> tau_r[$past(bc)] == $past(tau_r[bc]))
    else $error("Time constant changed while filtering off");
  AST_OOR_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    !oor_en_r[0] |=> !oor[0])
    else $error("Out-of-range flag set with check disabled");
  AST_OOR_LOW: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_CHECK && en_r[cur_r] && oor_en_r[cur_r] && xin < min_r[cur_r])
    |=> oor[$past(cur_r)])
    else $error("Below minimum not flagged");
  AST_OOR_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_CHECK && en_r[cur_r] && oor_en_r[cur_r] && xin > max_r[cur_r])
    |=> oor[$past(cur_r)])
    else $error("Above maximum not flagged");
  AST_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_SAMPLE && !src_ok) |=> $stable(meas_r[cur_r]))
    else $error("Measurement changed on signal loss");
  AST_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r[0] && g_curve[0].wrap) |=> pend_r[0])
    else $error("Update cycle end did not request a refresh");
  AST_DISABLED: assert property (@(posedge clock) disable iff (sys_rst)
    !en_r[0] |=> (!pend_r[0] && g_curve[0].cnt_r == 16'h0000))
    else $error("Disabled curve requested a refresh");
  AST_NOFILT: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_FILT && !filt_en_r[cur_r]) |=> filt_r[cur_r] == $past(meas_r[cur_r]))
    else $error("Unfiltered input not passed through");
  AST_ROUND: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_ROUND && rnd_r[cur_r] != AISC_RND_FLOAT) |=> (out_r[cur_r] % `AISC_ONE) == 0)
    else $error("Integer output mode left a fraction");
  AST_IRQ_DONE: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == S_ROUND && mask_r[4 + cur_r]) |=> ##1 irq)
    else $error("Masked-in update event gave no interrupt");

endmodule

// *** aisc_meas_model.sv ***
`timescale 1ns/100ps
`include "aisc_defines.svh"

// Measurement channels (mA, input voltage, RTD) in front of the curves
module aisc_meas_model (
  output logic signed [31:0] src_data [`AISC_NSRC],
  output logic [`AISC_NSRC-1:0] src_valid
);
  logic signed [31:0] val_r [`AISC_NSRC];
  logic [`AISC_NSRC-1:0] ok_r;

  // Set one channel; the bench calls it just after a rising edge
  task automatic set_src(input int i, input logic signed [31:0] v, input logic ok);
    val_r[i] <= v;
    ok_r[i] <= ok;
  endtask

  // A lost channel shows the inverse, so a held value cannot pass by luck
  always_comb begin
    for (int i = 0; i < `AISC_NSRC; i++) begin
      src_data[i] = ok_r[i] ? val_r[i] : ~val_r[i];
    end
    src_valid = ok_r;
  end

  // All channels present and at zero
  initial begin
    ok_r = '1;
    for (int i = 0; i < `AISC_NSRC; i++) begin
      val_r[i] = 32'sh0;
    end
  end
endmodule

// *** analog_input_scaling_curve_bench.sv ***
`timescale 1ns/100ps
`include "aisc_defines.svh"

module analog_input_scaling_curve_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic signed [31:0] src_data [`AISC_NSRC];
  logic [`AISC_NSRC-1:0] src_valid;
  logic [3:0] oor;
  logic irq;
  int mismatches = 0;
  int checks = 0;
  logic [31:0] q;
  logic [11:0] da [7] = '{12'h000, 12'h010, 12'h014, 12'h024, 12'h004, 12'h00c, 12'h800};
  logic [31:0] de [7] = '{32'h0, 32'h1e, 32'h3, 32'h186a0, 32'h0, 32'h0, 32'h0};
  logic [31:0] eo [4] = '{32'h1e23a, 32'h186a0, 32'h30d40, 32'h186a0};

  // 25 ns period
  always #12.5 clock = ~clock;

  // Short settings step keeps an update cycle to a few hundred clocks
  aisc_top #(.STEP_CYCLES(20)) aisc_top_inst (
    .clock(clock),
    .sys_rst(sys_rst),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_sel(wb_sel),
    .wb_adr(wb_adr),
    .wb_wdat(wb_wdat),
    .wb_rdat(wb_rdat),
    .wb_ack(wb_ack),
    .src_data(src_data),
    .src_valid(src_valid),
    .oor(oor),
    .irq(irq)
  );

  aisc_meas_model aisc_meas_model_inst (
    .src_data(src_data),
    .src_valid(src_valid)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; ack and read data are taken at the same rising edge
  task automatic wb(input logic [11:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge clock);
    while (wb_ack !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    // A write lands at this edge; callers look at outputs once it has settled
    @(negedge clock);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic src(input logic signed [31:0] v, input logic ok);
    @(posedge clock);
    aisc_meas_model_inst.set_src(0, v, ok);
  endtask

  // Two done events, so the second surely sampled the new input
  task automatic wait_upd();
    int n;
    repeat (2) begin
      wb(12'h400, 1'b1, 32'h10);
      n = 0;
      q = 32'h0;
      while (q[4] !== 1'b1 && n < 400) begin
        wb(12'h400, 1'b0, 32'h0);
        n++;
      end
      if (n >= 400) begin
        mismatches++;
        final_report();
      end
    end
  endtask

  task automatic test_defaults();
    for (int i = 0; i < 7; i++) begin
      wb(da[i], 1'b0, 32'h0);
      check(q, de[i]);
    end
    wb(12'h004, 1'b1, 32'h5);
    wb(12'h004, 1'b0, 32'h0);
    check(q, 32'h0);
    check({27'h0, irq, oor}, 32'h0);
    $display("defaults done");
  endtask

  task automatic test_scaling();
    wb(12'h010, 1'b1, 32'ha);
    wb(12'h084, 1'b1, 32'h000f4240);
    src(32'sh3039, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wb(12'h000, 1'b1, {26'h0, m[1:0], 4'h1});
      wait_upd();
      wb(12'h018, 1'b0, 32'h0);
      check(q, 32'h3039);
      wb(12'h01c, 1'b0, 32'h0);
      check(q, eo[m]);
    end
    // Third point turns the flat top into a rising segment
    wb(12'h028, 1'b1, 32'h30d40);
    wb(12'h088, 1'b1, 32'h002dc6c0);
    wb(12'h014, 1'b1, 32'h7);
    wb(12'h000, 1'b1, 32'h1);
    src(32'sh249f0, 1'b1);
    wait_upd();
    wb(12'h01c, 1'b0, 32'h0);
    check(q, 32'h1e8480);
    $display("scaling done");
  endtask

  task automatic test_range();
    wb(12'h00c, 1'b1, 32'hc350);
    wb(12'h404, 1'b1, 32'h1);
    wb(12'h000, 1'b1, 32'h5);
    src(32'shea60, 1'b1);
    wait_upd();
    check({27'h0, irq, oor}, 32'h11);
    wb(12'h400, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h0);
    src(32'sh61a8, 1'b1);
    wait_upd();
    check({28'h0, oor}, 32'h0);
    src(-32'sh5, 1'b1);
    wait_upd();
    check({27'h0, irq, oor}, 32'h11);
    wb(12'h000, 1'b1, 32'h1);
    src(32'shea60, 1'b1);
    wait_upd();
    check({28'h0, oor}, 32'h0);
    wb(12'h400, 1'b1, 32'h1);
    $display("range done");
  endtask

  task automatic test_loss();
    src(32'sh9c40, 1'b1);
    wait_upd();
    src(32'sh11170, 1'b0);
    wait_upd();
    wb(12'h018, 1'b0, 32'h0);
    check(q, 32'h9c40);
    src(32'sh9c40, 1'b1);
    // Second channel reached through the source select
    @(posedge clock);
    aisc_meas_model_inst.set_src(1, 32'sh7530, 1'b1);
    wb(12'h000, 1'b1, 32'h101);
    wait_upd();
    wb(12'h018, 1'b0, 32'h0);
    check(q, 32'h7530);
    wb(12'h000, 1'b1, 32'h1);
    $display("loss done");
  endtask

  // Time constant twice the update period, as a slow-disturbance setting
  task automatic test_filter();
    wb(12'h000, 1'b1, 32'h3);
    wb(12'h004, 1'b1, 32'h14);
    wb(12'h004, 1'b0, 32'h0);
    check(q, 32'h14);
    wb(12'h404, 1'b1, 32'h10);
    src(32'sh186a0, 1'b1);
    wait_upd();
    check({31'h0, irq}, 32'h1);
    wb(12'h01c, 1'b0, 32'h0);
    check({31'h0, $signed(q) < 32'sh000f4240}, 32'h1);
    $display("filter done");
  endtask

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    test_defaults();
    test_scaling();
    test_range();
    test_loss();
    test_filter();
    final_report();
  end
endmodule
